// ### rtl/dap_pkg.sv
package dap_pkg;

    // Bus and counter widths.
    localparam int unsigned AW = 4;
    localparam int unsigned DW = 16;
    localparam int unsigned CW = 8;

    // Register offsets on the plain register port.
    localparam logic [AW-1:0] OFS_PER_A   = 4'h0;
    localparam logic [AW-1:0] OFS_PER_B   = 4'h1;
    localparam logic [AW-1:0] OFS_ON_A    = 4'h2;
    localparam logic [AW-1:0] OFS_ON_B    = 4'h3;
    localparam logic [AW-1:0] OFS_MODE    = 4'h4;
    localparam logic [AW-1:0] OFS_PINSEL  = 4'h5;
    localparam logic [AW-1:0] OFS_UPDATA  = 4'h6;
    localparam logic [AW-1:0] OFS_STATUS  = 4'h7;

    // Field positions.
    localparam int unsigned MODE_INDEP_BIT = 8;
    localparam int unsigned PINSEL_B_BIT   = 7;
    localparam int unsigned UPD_PIN_A_BIT  = 1;
    localparam int unsigned STAT_PWM_A_BIT = 0;
    localparam int unsigned STAT_PWM_B_BIT = 1;
    localparam int unsigned STAT_CNT_LSB   = 8;

    // Reset values.
    localparam logic [CW-1:0] PER_RST    = 8'hff;
    localparam logic [CW-1:0] ON_RST     = 8'h00;
    localparam logic          MODE_RST   = 1'h0;
    localparam logic [7:0]    PINSEL_RST = 8'hff;
    localparam logic          UPD_RST    = 1'h1;

    // Time base: one count every two instruction-clock cycles.
    localparam int unsigned TICK_CYCLES = 2;

    // One register request, all strobes and data of one cycle.
    typedef struct packed {
        logic [AW-1:0] addr;
        logic [DW-1:0] wdata;
        logic          wr;
        logic          rd;
    } dap_req_s;

    // Channel phase: waiting for its first rising point, or running.
    typedef enum logic [1:0] {
        DAP_WAIT = 2'b01,
        DAP_RUN  = 2'b10
    } dap_ph_e;

endpackage

// ### rtl/dap_div.sv
`timescale 1ns/10ps
// Divide-by-N enable: one-cycle pulse every DIV clocks, realigned by clear.
module dap_div #(
    parameter int unsigned DIV = dap_pkg::TICK_CYCLES
) (
    input  wire logic clk_i,
    input  wire logic rst_b_i,
    input  wire logic clr_i,
    output logic      tick_o
);
    import dap_pkg::*;

    localparam int unsigned W = (DIV > 2) ? $clog2(DIV) : 1;
    localparam logic [W-1:0] LAST = W'(DIV - 1);

    logic [W-1:0] ph_q;
    logic [W-1:0] ph_d;

    // Phase counter wraps at DIV-1; a clear restarts the phase.
    always_comb
    begin
        if (clr_i || ph_q == LAST)
            ph_d = '0;
        else
            ph_d = ph_q + W'(1);
    end

    always_ff @(posedge clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
            ph_q <= '0;
        else
            ph_q <= ph_d;
    end

    assign tick_o = (ph_q == LAST) && !clr_i;

endmodule

// ### rtl/dap_chan.sv
`timescale 1ns/10ps
// One auxiliary PWM channel: period counter, held on-time and output compare.
module dap_chan #(
    parameter int unsigned         CW        = dap_pkg::CW,
    parameter dap_pkg::dap_ph_e    START_PH  = dap_pkg::DAP_RUN
) (
    input  wire logic          clk_i,
    input  wire logic          rst_b_i,
    input  wire logic          tick_i,
    input  wire logic          restart_i,
    input  wire logic          wait_i,
    input  wire logic          sync_i,
    input  wire logic [CW-1:0] per_i,
    input  wire logic [CW-1:0] on_i,
    output logic [CW-1:0]      cnt_o,
    output logic [CW-1:0]      act_on_o,
    output logic               pwm_o
);
    import dap_pkg::*;

    logic [CW-1:0] cnt_q;
    logic [CW-1:0] cnt_d;
    logic [CW-1:0] act_q;
    logic [CW-1:0] act_d;
    dap_ph_e       ph_q;
    dap_ph_e       ph_d;

    // Next counter state; the on-time is only taken at a period start.
    always_comb
    begin
        cnt_d = cnt_q;
        act_d = act_q;
        ph_d  = ph_q;
        if (restart_i)
        begin
            cnt_d = '0;
            act_d = on_i;
            ph_d  = wait_i ? DAP_WAIT : DAP_RUN;
        end
        // A channel left waiting when offset mode ends starts at the next tick.
        else if (tick_i && (sync_i || (ph_q == DAP_WAIT && !wait_i)))
        begin
            cnt_d = '0;
            act_d = on_i;
            ph_d  = DAP_RUN;
        end
        else if (tick_i && ph_q == DAP_RUN)
        begin
            // Greater-or-equal keeps a lowered period from running past it.
            if (cnt_q >= per_i)
            begin
                cnt_d = '0;
                act_d = on_i;
            end
            else
                cnt_d = cnt_q + CW'(1);
        end
    end

    always_ff @(posedge clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            cnt_q <= '0;
            act_q <= ON_RST;
            ph_q  <= START_PH;
        end
        else
        begin
            cnt_q <= cnt_d;
            act_q <= act_d;
            ph_q  <= ph_d;
        end
    end

    // High from period start until the on-time count; full duty past the period.
    assign pwm_o    = (ph_q == DAP_RUN) && ((cnt_q < act_q) || (act_q > per_i));
    assign cnt_o    = cnt_q;
    assign act_on_o = act_q;

endmodule

// ### rtl/dap_top.sv
// Contract
// - Mode bit set: independent; clear: offset.
// - Independent period is two cycles times (period+1).
// - High time is two cycles times on-time.
// - On-time above period gives full duty.
// - Offset mode shares first period, separate on-times.
// - Second rising edge delayed two times (offset+1).
// - New on-time applies at next period start.
// - Period write clears counters, restarts cycles.
// - Mode bit resets clear: offset mode.
// - Periods reset all ones, on-times zero.
// - Select bit set: general pin; clear: PWM.
// - All select bits set after reset.
// - Upper data bit 1 selects first pin.
`timescale 1ns/10ps
module dap_top (
    input  wire logic                   clk_i,
    input  wire logic                   rst_b_i,
    input  wire dap_pkg::dap_req_s      req_i,
    output logic [dap_pkg::DW-1:0]      rdata_o,
    input  wire logic                   gp_eight_do_i,
    input  wire logic                   gp_eight_oe_i,
    input  wire logic                   gp_seven_do_i,
    input  wire logic                   gp_seven_oe_i,
    output logic                        first_pin_o,
    output logic                        first_pin_oe_o,
    output logic                        second_pin_o,
    output logic                        second_pin_oe_o
);
    import dap_pkg::*;

    // True when the request addresses the given offset.
    function automatic logic hit(input logic [AW-1:0] addr, input logic [AW-1:0] ofs);
        hit = (addr == ofs);
    endfunction

    logic [CW-1:0] per_a_q;
    logic [CW-1:0] per_a_d;
    logic [CW-1:0] per_b_q;
    logic [CW-1:0] per_b_d;
    logic [CW-1:0] on_a_q;
    logic [CW-1:0] on_a_d;
    logic [CW-1:0] on_b_q;
    logic [CW-1:0] on_b_d;
    logic          indep_q;
    logic          indep_d;
    logic [7:0]    pinsel_q;
    logic [7:0]    pinsel_d;
    logic          upd_q;
    logic          upd_d;
    logic [DW-1:0] rdata_d;
    logic          pin_a_d;
    logic          pin_a_oe_d;
    logic          pin_b_d;
    logic          pin_b_oe_d;

    logic          wr_per;
    logic          tick;
    logic          sync_b;
    logic [CW-1:0] per_b_eff;
    logic [CW-1:0] cnt_a;
    logic [CW-1:0] cnt_b;
    logic [CW-1:0] act_a;
    logic [CW-1:0] act_b;
    logic          pwm_a;
    logic          pwm_b;

    // Any period write restarts both channels and the time base.
    assign wr_per = req_i.wr && (hit(req_i.addr, OFS_PER_A) || hit(req_i.addr, OFS_PER_B));

    // Offset mode runs the second channel on the first period.
    assign per_b_eff = indep_q ? per_b_q : per_a_q;

    // The second channel restarts one count after the first reaches the offset value.
    // A wrong offset above the first period simply never matches.
    assign sync_b = !indep_q && (cnt_a == per_b_q);

    // Register writes.
    always_comb
    begin
        per_a_d  = per_a_q;
        per_b_d  = per_b_q;
        on_a_d   = on_a_q;
        on_b_d   = on_b_q;
        indep_d  = indep_q;
        pinsel_d = pinsel_q;
        upd_d    = upd_q;
        if (req_i.wr)
        begin
            if (hit(req_i.addr, OFS_PER_A))
                per_a_d = req_i.wdata[CW-1:0];
            if (hit(req_i.addr, OFS_PER_B))
                per_b_d = req_i.wdata[CW-1:0];
            if (hit(req_i.addr, OFS_ON_A))
                on_a_d = req_i.wdata[CW-1:0];
            if (hit(req_i.addr, OFS_ON_B))
                on_b_d = req_i.wdata[CW-1:0];
            if (hit(req_i.addr, OFS_MODE))
                indep_d = req_i.wdata[MODE_INDEP_BIT];
            if (hit(req_i.addr, OFS_PINSEL))
                pinsel_d = req_i.wdata[7:0];
            if (hit(req_i.addr, OFS_UPDATA))
                upd_d = req_i.wdata[UPD_PIN_A_BIT];
        end
    end

    // Reset values: offset mode, slowest period, zero on-time, pins general.
    always_ff @(posedge clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            per_a_q  <= PER_RST;
            per_b_q  <= PER_RST;
            on_a_q   <= ON_RST;
            on_b_q   <= ON_RST;
            indep_q  <= MODE_RST;
            pinsel_q <= PINSEL_RST;
            upd_q    <= UPD_RST;
        end
        else
        begin
            per_a_q  <= per_a_d;
            per_b_q  <= per_b_d;
            on_a_q   <= on_a_d;
            on_b_q   <= on_b_d;
            indep_q  <= indep_d;
            pinsel_q <= pinsel_d;
            upd_q    <= upd_d;
        end
    end

    // Time base of two instruction-clock cycles.
    dap_div #(
        .DIV (TICK_CYCLES)
    ) u_div (
        .clk_i   (clk_i),
        .rst_b_i (rst_b_i),
        .clr_i   (wr_per),
        .tick_o  (tick)
    );

    // First channel always runs on its own period.
    dap_chan #(
        .CW       (CW),
        .START_PH (DAP_RUN)
    ) u_chan_a (
        .clk_i     (clk_i),
        .rst_b_i   (rst_b_i),
        .tick_i    (tick),
        .restart_i (wr_per),
        .wait_i    (1'b0),
        .sync_i    (1'b0),
        .per_i     (per_a_q),
        .on_i      (on_a_q),
        .cnt_o     (cnt_a),
        .act_on_o  (act_a),
        .pwm_o     (pwm_a)
    );

    // Second channel waits for the offset point while in offset mode.
    dap_chan #(
        .CW       (CW),
        .START_PH (DAP_WAIT)
    ) u_chan_b (
        .clk_i     (clk_i),
        .rst_b_i   (rst_b_i),
        .tick_i    (tick),
        .restart_i (wr_per),
        .wait_i    (!indep_q),
        .sync_i    (sync_b),
        .per_i     (per_b_eff),
        .on_i      (on_b_q),
        .cnt_o     (cnt_b),
        .act_on_o  (act_b),
        .pwm_o     (pwm_b)
    );

    // Pin routing and read data; a set select bit 7 hands the second pin, a set upper data bit the first pin, to the general port.
    always_comb
    begin
        pin_a_d    = upd_q ? gp_eight_do_i : pwm_a;
        pin_a_oe_d = upd_q ? gp_eight_oe_i : 1'b1;
        pin_b_d    = pinsel_q[PINSEL_B_BIT] ? gp_seven_do_i : pwm_b;
        pin_b_oe_d = pinsel_q[PINSEL_B_BIT] ? gp_seven_oe_i : 1'b1;
        rdata_d    = '0;
        if (req_i.rd)
        begin
            unique case (req_i.addr)
                OFS_PER_A:  rdata_d = {8'h00, per_a_q};
                OFS_PER_B:  rdata_d = {8'h00, per_b_q};
                OFS_ON_A:   rdata_d = {8'h00, on_a_q};
                OFS_ON_B:   rdata_d = {8'h00, on_b_q};
                OFS_MODE:   rdata_d[MODE_INDEP_BIT] = indep_q;
                OFS_PINSEL: rdata_d = {8'h00, pinsel_q};
                OFS_UPDATA: rdata_d[UPD_PIN_A_BIT] = upd_q;
                OFS_STATUS:
                begin
                    rdata_d[STAT_PWM_A_BIT] = pwm_a;
                    rdata_d[STAT_PWM_B_BIT] = pwm_b;
                    rdata_d[STAT_CNT_LSB +: CW] = cnt_a;
                end
                default:    rdata_d = '0;
            endcase
        end
    end

    // Every output leaves from a flip-flop; pins lag the compare by one clock.
    // The lag costs a cycle of edge placement but keeps the pins free of glitches.
    always_ff @(posedge clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            rdata_o         <= '0;
            first_pin_o     <= 1'b0;
            first_pin_oe_o  <= 1'b0;
            second_pin_o    <= 1'b0;
            second_pin_oe_o <= 1'b0;
        end
        else
        begin
            rdata_o         <= rdata_d;
            first_pin_o     <= pin_a_d;
            first_pin_oe_o  <= pin_a_oe_d;
            second_pin_o    <= pin_b_d;
            second_pin_oe_o <= pin_b_oe_d;
        end
    end

    // Helper flag: low in reset and in the first cycle after reset release.
    logic seen_q;

    always_ff @(posedge clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
            seen_q <= 1'b0;
        else
            seen_q <= 1'b1;
    end

    default clocking cb @(posedge clk_i);
    endclocking

    default disable iff (!rst_b_i);

    // Reset state of registers.
    reset_values_a: assert property (
        !seen_q |-> per_a_q == 8'hff && per_b_q == 8'hff && on_a_q == 8'h00 && on_b_q == 8'h00)
        else $error("register reset values wrong");

    reset_mode_a: assert property (
        !seen_q |-> !indep_q && pinsel_q == 8'hff)
        else $error("mode or pin select reset wrong");

    // The release edge itself may still see reset in the flops, so wait a cycle.
    pinsel_reset_a: assert property (
        !seen_q ##1 seen_q
        |=> second_pin_oe_o == $past(gp_seven_oe_i) && first_pin_o == $past(gp_eight_do_i))
        else $error("pins not general after reset");

    // Counting and period.
    tick_alt_a: assert property (
        tick |=> !tick)
        else $error("time base ticks faster than every two cycles");

    count_step_a: assert property (
        tick && cnt_a < per_a_q && !wr_per |=> cnt_a == $past(cnt_a) + 8'h01)
        else $error("first counter did not step");

    count_hold_a: assert property (
        !tick && !wr_per |=> cnt_a == $past(cnt_a))
        else $error("first counter moved without a tick");

    period_wrap_a: assert property (
        tick && cnt_a == per_a_q && !wr_per |=> cnt_a == 8'h00)
        else $error("first counter did not wrap at period");

    indep_wrap_b_a: assert property (
        indep_q && tick && cnt_b == per_b_q && !wr_per
        |=> cnt_b == 8'h00)
        else $error("second counter ignored its own period");

    period_clear_a: assert property (
        wr_per |=> cnt_a == 8'h00 && cnt_b == 8'h00 && !tick)
        else $error("period write did not clear counters");

    shared_period_a: assert property (
        !indep_q && tick && cnt_b == per_a_q && !wr_per
        |=> cnt_b == 8'h00)
        else $error("offset mode lost the shared period");

    offset_start_a: assert property (
        !indep_q && tick && cnt_a == per_b_q && !wr_per && !req_i.wr
        |=> cnt_b == 8'h00 && cnt_a == per_b_q + 8'h01 - ((per_b_q == per_a_q) ? per_a_q + 8'h01 : 8'h00))
        else $error("second channel not started at offset");

    offset_wait_a: assert property (
        !indep_q && wr_per |=> !pwm_b && cnt_b == 8'h00)
        else $error("second output ran before its offset point");

    // Output shape.
    zero_low_a: assert property (
        act_a == 8'h00 |-> !pwm_a)
        else $error("zero on-time drove output high");

    full_duty_a: assert property (
        act_b > per_b_eff && cnt_b != 8'h00 |-> pwm_b)
        else $error("on-time past period not full duty");

    rise_start_a: assert property (
        cnt_a == 8'h00 && act_a != 8'h00 |-> pwm_a)
        else $error("output not high at period start");

    on_hold_a: assert property (
        !(tick && cnt_a >= per_a_q) && !wr_per |=> act_a == $past(act_a))
        else $error("on-time changed inside a period");

    pin_route_a: assert property (
        !pinsel_q[PINSEL_B_BIT] |=> second_pin_o == $past(pwm_b) && second_pin_oe_o)
        else $error("second pin not carrying the output");

    pin_first_a: assert property (
        !upd_q |=> first_pin_o == $past(pwm_a) && first_pin_oe_o)
        else $error("first pin not carrying the output");

    // Pins handed to the general port.
    first_general_a: assert property (
        seen_q && upd_q |=> first_pin_o == $past(gp_eight_do_i)
            && first_pin_oe_o == $past(gp_eight_oe_i))
        else $error("first pin not handed to the general port");

    second_general_a: assert property (
        seen_q && pinsel_q[PINSEL_B_BIT] |=> second_pin_o == $past(gp_seven_do_i)
            && second_pin_oe_o == $past(gp_seven_oe_i))
        else $error("second pin not handed to the general port");

    // Main scenarios.
    cov_indep_c: cover property (indep_q && tick && cnt_b == per_b_q);
    cov_offset_c: cover property (!indep_q && tick && sync_b);
    cov_full_c: cover property (act_a > per_a_q && pwm_a);
    cov_restart_c: cover property (wr_per ##2 tick);
    cov_general_c: cover property (seen_q && pinsel_q[PINSEL_B_BIT] && !gp_seven_oe_i);

endmodule

// ### test/dap_load.sv
`timescale 1ns/10ps
// Far-side load on both shared pins: a filter input with a pull-down that
// timestamps every rising and falling edge it sees, counted in core clocks.
module dap_load (
    input  wire logic        clk_i,
    input  wire logic        rst_b_i,
    input  wire logic [1:0]  pin_i,
    input  wire logic [1:0]  oe_i,
    output logic [1:0]       lvl_o,
    output logic [1:0][31:0] rise_o,
    output logic [1:0][31:0] fall_o
);
    logic [31:0] cyc_q;
    logic [1:0]  last_q;

    // A released pin is pulled low, so an undriven line never shows a stale level.
    assign lvl_o = pin_i & oe_i;

    // Edge stamps are taken on the core clock, which is the only time base here.
    always_ff @(posedge clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            cyc_q  <= '0;
            last_q <= '0;
            rise_o <= '0;
            fall_o <= '0;
        end
        else
        begin
            cyc_q  <= cyc_q + 32'h1;
            last_q <= lvl_o;
            for (int i = 0; i < 2; i++)
            begin
                if (lvl_o[i] && !last_q[i])
                    rise_o[i] <= cyc_q;
                if (!lvl_o[i] && last_q[i])
                    fall_o[i] <= cyc_q;
            end
        end
    end
endmodule

// ### test/tb_dual_aux_pwm_timer.sv
`timescale 1ns/10ps
module tb_dual_aux_pwm_timer;
    import dap_pkg::*;

    logic                clk_i   = 1'b0;
    logic                rst_b_i = 1'b0;
    dap_req_s            req     = '0;
    logic [DW-1:0]       rdata_o;
    logic                gp8_do  = 1'b1;
    logic                gp8_oe  = 1'b1;
    logic                gp7_do  = 1'b0;
    logic                gp7_oe  = 1'b1;
    logic                first_pin_o;
    logic                first_pin_oe_o;
    logic                second_pin_o;
    logic                second_pin_oe_o;
    logic [1:0]          lvl;
    logic [1:0][31:0]    rise_t;
    logic [1:0][31:0]    fall_t;
    logic [31:0]         r1;
    logic [31:0]         r2;
    logic [31:0]         f1;
    int                  n_fail   = 0;
    int                  n_checks = 0;
    int                  k;

    // Free-running 40 MHz core clock.
    always #12.5 clk_i = ~clk_i;

    dap_top u_dut (
        .clk_i           (clk_i),
        .rst_b_i         (rst_b_i),
        .req_i           (req),
        .rdata_o         (rdata_o),
        .gp_eight_do_i   (gp8_do),
        .gp_eight_oe_i   (gp8_oe),
        .gp_seven_do_i   (gp7_do),
        .gp_seven_oe_i   (gp7_oe),
        .first_pin_o     (first_pin_o),
        .first_pin_oe_o  (first_pin_oe_o),
        .second_pin_o    (second_pin_o),
        .second_pin_oe_o (second_pin_oe_o)
    );

    dap_load u_far (
        .clk_i   (clk_i),
        .rst_b_i (rst_b_i),
        .pin_i   ({second_pin_o, first_pin_o}),
        .oe_i    ({second_pin_oe_o, first_pin_oe_o}),
        .lvl_o   (lvl),
        .rise_o  (rise_t),
        .fall_o  (fall_t)
    );

    // Single exit point so a hang and a normal end print the same verdict.
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            n_fail++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // One-cycle write strobe; the slave never stalls.
    task automatic wr(input logic [AW-1:0] a, input logic [DW-1:0] d);
        @(posedge clk_i);
        req.addr  <= a;
        req.wdata <= d;
        req.wr    <= 1'b1;
        @(posedge clk_i);
        req.wr    <= 1'b0;
    endtask

    // Read data stand only in the cycle after the strobe, so sample there.
    task automatic rd(input logic [AW-1:0] a, input logic [DW-1:0] exp);
        @(posedge clk_i);
        req.addr <= a;
        req.rd   <= 1'b1;
        @(posedge clk_i);
        req.rd   <= 1'b0;
        #1;
        chk(32'(rdata_o), 32'(exp));
    endtask

    // Wait, bounded, for the next rising or falling stamp on pin i.
    task automatic wait_edge(input int i, input bit fall, output logic [31:0] t);
        logic [31:0] v;
        v = fall ? fall_t[i] : rise_t[i];
        t = v;
        for (int n = 0; n < 600 && t === v; n++)
        begin
            @(posedge clk_i);
            #1;
            t = fall ? fall_t[i] : rise_t[i];
        end
        if (t === v)
        begin
            n_fail++;
            report_and_stop();
        end
    endtask

    // Main sequence: reset state, independent mode, on-time hold-off,
    // period restart, offset mode, then handing a pin back.
    initial
    begin
        repeat (6) @(posedge clk_i);
        rst_b_i <= 1'b1;
        rd(OFS_PER_A, 16'h00ff);
        rd(OFS_PER_B, 16'h00ff);
        rd(OFS_ON_A, 16'h0000);
        rd(OFS_ON_B, 16'h0000);
        rd(OFS_MODE, 16'h0000);
        rd(OFS_PINSEL, 16'h00ff);
        rd(OFS_UPDATA, 16'h0002);
        rd(4'h8, 16'h0000);
        chk(32'(first_pin_o), 32'h1);
        chk(32'(second_pin_o), 32'h0);
        wr(OFS_MODE, 16'h0100);
        wr(OFS_ON_A, 16'h0002);
        wr(OFS_ON_B, 16'h0002);
        wr(OFS_PINSEL, 16'h007f);
        wr(OFS_UPDATA, 16'h0000);
        wr(OFS_PER_B, 16'h0005);
        wr(OFS_PER_A, 16'h0003);
        rd(OFS_PER_A, 16'h0003);
        chk(32'(first_pin_oe_o), 32'h1);
        chk(32'(second_pin_oe_o), 32'h1);
        // Channel A: period 2*(3+1), high 2*2; channel B runs its own period.
        wait_edge(0, 0, r1);
        wait_edge(0, 1, f1);
        chk(f1 - r1, 32'd4);
        wait_edge(0, 0, r2);
        chk(r2 - r1, 32'd8);
        wait_edge(1, 0, r1);
        wait_edge(1, 0, r2);
        chk(r2 - r1, 32'd12);
        // A shorter on-time written mid-pulse must not cut the running pulse.
        wait_edge(0, 0, r1);
        wr(OFS_ON_A, 16'h0001);
        wait_edge(0, 1, f1);
        chk(f1 - r1, 32'd4);
        wait_edge(0, 0, r1);
        wait_edge(0, 1, f1);
        chk(f1 - r1, 32'd2);
        // A period write in the low phase restarts the cycle at once.
        wr(OFS_PER_A, 16'h0003);
        #1;
        k = 0;
        while (first_pin_o !== 1'b1 && k < 20)
        begin
            @(posedge clk_i);
            #1;
            k++;
        end
        chk(32'(k), 32'd1);
        // On-time above the period holds channel B high all the time.
        wr(OFS_ON_B, 16'h0009);
        wait_edge(1, 0, r1);
        k = 0;
        repeat (30)
        begin
            @(posedge clk_i);
            #1;
            k += int'(second_pin_o === 1'b1);
        end
        chk(32'(k), 32'd30);
        // Offset mode: shared period 2*(9+1), B rises 2*(3+1) after A.
        wr(OFS_MODE, 16'h0000);
        wr(OFS_ON_A, 16'h0002);
        wr(OFS_ON_B, 16'h0003);
        wr(OFS_PER_B, 16'h0003);
        wr(OFS_PER_A, 16'h0009);
        // Counter cleared, first output high, second still waiting.
        rd(OFS_STATUS, 16'h0001);
        wait_edge(0, 0, r1);
        wait_edge(1, 0, r2);
        chk(r2 - r1, 32'd8);
        wait_edge(1, 1, f1);
        chk(f1 - r2, 32'd6);
        wait_edge(1, 0, r1);
        chk(r1 - r2, 32'd20);
        // Handing the second pin back to the general port.
        wr(OFS_PINSEL, 16'h00ff);
        gp7_oe <= 1'b0;
        repeat (3) @(posedge clk_i);
        #1;
        chk(32'(second_pin_oe_o), 32'h0);
        chk(32'(lvl[1]), 32'h0);
        report_and_stop();
    end
endmodule
